//--- bench/dbf_host_model.sv
// Host bus model driving one queue port
`timescale 1ns/1ps
`default_nettype none
module dbf_host_model
	import dbf_pkg::*;
(
	// System clock
	input  wire logic              clk,
	// Port pins
	output logic                   port_clock,
	output logic                   select_n,
	output logic                   enable,
	output logic                   read,
	output logic      [DATA_W-1:0] data
);
	// Idle pin levels
	initial begin
		port_clock = 1'h0;
		select_n = 1'h1;
		enable = 1'h0;
		read = 1'h0;
		data = 36'h0;
	end

	// Wait some clocks, then step just past the edge
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One port clock period; controls held well around the rising edge
	task automatic xfer(input logic sn, input logic en, input logic rd,
		input logic [DATA_W-1:0] d);
		wait_clk(1);
		select_n = sn;
		enable = en;
		read = rd;
		data = rd ? ~data : d;
		wait_clk(4);
		port_clock = 1'h1;
		wait_clk(4);
		port_clock = 1'h0;
		enable = 1'h0;
		data = ~data;     // Released bus no longer shows the last word
		wait_clk(2);
	endtask
endmodule // dbf_host_model
`default_nettype wire

//--- bench/dbf_port_flags_tb.sv
// Self-checking bench for the two-port queue flag block
`timescale 1ns/1ps
`default_nettype none
module dbf_port_flags_tb;
	import dbf_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct {
		logic pb; logic sn; logic en; logic rd; logic [35:0] d;
		logic ef; logic ff; logic [35:0] q;
	} dbf_row_t;
	logic        clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic        fall_through_timing = 1'h1;
	logic        a_clk, a_sn, a_en, a_rd, a_oe, a_ef, a_ff, a_ae_n, a_af_n;
	logic        b_clk, b_sn, b_en, b_rd, b_oe, b_ef, b_ff, b_ae_n, b_af_n;
	logic [35:0] a_din, a_dout, b_din, b_dout;
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;
	dbf_row_t    rows [10];

	// Clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	dbf_host_model host_a_i (.clk(clk), .port_clock(a_clk), .select_n(a_sn),
		.enable(a_en), .read(a_rd), .data(a_din));
	dbf_host_model host_b_i (.clk(clk), .port_clock(b_clk), .select_n(b_sn),
		.enable(b_en), .read(b_rd), .data(b_din));
	dbf_port_flags dbf_port_flags_i (.clk(clk), .sys_rst(sys_rst),
		.fall_through_timing(fall_through_timing),
		.port_a_clock(a_clk), .port_a_select_n(a_sn), .port_a_enable(a_en),
		.port_a_read(a_rd), .port_a_data_in(a_din), .port_a_data_out(a_dout),
		.port_a_data_oe(a_oe), .port_a_empty_flag(a_ef), .port_a_full_flag(a_ff),
		.port_a_almost_empty_n(a_ae_n), .port_a_almost_full_n(a_af_n),
		.port_b_clock(b_clk), .port_b_select_n(b_sn), .port_b_enable(b_en),
		.port_b_read(b_rd), .port_b_data_in(b_din), .port_b_data_out(b_dout),
		.port_b_data_oe(b_oe), .port_b_empty_flag(b_ef), .port_b_full_flag(b_ff),
		.port_b_almost_empty_n(b_ae_n), .port_b_almost_full_n(b_af_n));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic op(input logic pb, input logic sn, input logic en, input logic rd,
		input logic [35:0] d);
		if (pb) host_b_i.xfer(sn, en, rd, d);
		else host_a_i.xfer(sn, en, rd, d);
	endtask

	task automatic do_reset();
		@(posedge clk);
		#1 sys_rst = 1'h1;
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'h0;
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rows = '{
			'{0, 0, 1, 0, 36'h1_2345_6789, 0, 1, 36'h0},
			'{0, 1, 1, 0, 36'hF_0000_000F, 0, 1, 36'h0},
			'{0, 0, 0, 0, 36'hE_0000_000E, 0, 1, 36'h0},
			'{1, 0, 0, 1, 36'h0,           1, 1, 36'h0},
			'{1, 0, 1, 1, 36'h0,           0, 1, 36'h1_2345_6789},
			'{1, 0, 1, 0, 36'h0_AAAA_5555, 0, 1, 36'h0},
			'{1, 0, 1, 1, 36'h0,           0, 1, 36'h1_2345_6789},
			'{0, 0, 0, 1, 36'h0,           1, 1, 36'h0},
			'{0, 0, 1, 1, 36'h0,           0, 1, 36'h0_AAAA_5555},
			'{1, 1, 1, 1, 36'h0,           0, 1, 36'h1_2345_6789}};
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'h0;
		// Flags stay low until each port sees an edge
		check(a_ff, 1'h0);
		op(0, 1, 0, 0, 36'h0);
		op(1, 1, 0, 0, 36'h0);
		check(a_ff, 1'h1);
		check(b_ff, 1'h1);
		// Table of ordinary transfers in standard mode
		for (int i = 0; i < 10; i++) begin
			op(rows[i].pb, rows[i].sn, rows[i].en, rows[i].rd, rows[i].d);
			check(rows[i].pb ? b_ef : a_ef, rows[i].ef);
			check(rows[i].pb ? b_ff : a_ff, rows[i].ff);
			check(rows[i].pb ? b_oe : a_oe, ~rows[i].sn & rows[i].rd);
			if (rows[i].rd) check(rows[i].pb ? b_dout : a_dout, rows[i].q);
		end
		// Fill the A-to-B queue until it refuses
		for (int i = 0; i < 64; i++) begin
			op(0, 0, 1, 0, 36'h100 + i);
			if (i == 0) check(b_ef, 1'h0);
		end
		check(a_ff, 1'h0);
		check(a_af_n, 1'h0);
		op(0, 0, 1, 0, 36'hD_EAD0_0000);
		op(1, 0, 0, 1, 36'h0);
		check(b_ef, 1'h1);
		check(b_ae_n, 1'h1);
		// Drain in order; the refused word must not appear
		for (int i = 0; i < 64; i++) begin
			op(1, 0, 1, 1, 36'h0);
			check(b_dout, 36'h100 + i);
		end
		check(b_ef, 1'h0);
		check(b_af_n, 1'h1);
		check(a_ae_n, 1'h0);
		check(a_ff, 1'h0);
		op(0, 1, 0, 0, 36'h0);
		check(a_ff, 1'h1);
		// Both ports clocked together
		fork
			op(0, 0, 1, 0, 36'h7_0000_0001);
			op(1, 0, 1, 0, 36'h8_0000_0002);
		join
		fork
			op(0, 0, 0, 1, 36'h0);
			op(1, 0, 0, 1, 36'h0);
		join
		check(a_ef, 1'h1);
		check(b_ef, 1'h1);
		fork
			op(0, 0, 1, 1, 36'h0);
			op(1, 0, 1, 1, 36'h0);
		join
		check(a_dout, 36'h8_0000_0002);
		check(b_dout, 36'h7_0000_0001);
		// Fill the B-to-A queue from port B; the last write is refused
		for (int i = 0; i < 65; i++) begin
			op(1, 0, 1, 0, 36'h200 + i);
		end
		check(b_ff, 1'h0);
		check(b_af_n, 1'h0);
		op(0, 0, 0, 1, 36'h0);
		check(a_ef, 1'h1);
		check(a_ae_n, 1'h1);
		// Fall-through mode after a second reset
		fall_through_timing = 1'h0;
		do_reset();
		op(0, 1, 0, 0, 36'h0);
		op(1, 1, 0, 0, 36'h0);
		op(0, 0, 1, 0, 36'h3_0000_0033);
		op(0, 0, 1, 0, 36'h4_0000_0044);
		check(b_ef, 1'h0);
		op(1, 0, 0, 1, 36'h0);
		check(b_ef, 1'h1);
		check(b_dout, 36'h3_0000_0033);
		op(1, 0, 1, 1, 36'h0);
		check(b_ef, 1'h1);
		check(b_dout, 36'h4_0000_0044);
		op(1, 0, 1, 1, 36'h0);
		check(b_ef, 1'h0);
		op(1, 0, 1, 0, 36'h5_0000_0055);
		check(b_ff, 1'h1);
		op(0, 0, 0, 1, 36'h0);
		check(a_ef, 1'h1);
		check(a_dout, 36'h5_0000_0055);
		check(a_ff, 1'h1);
		print_verdict();
	end
endmodule // dbf_port_flags_tb
`default_nettype wire

//--- rtl/dbf_pkg.sv
// Shared constants and types for the two-port queue flag block
// Notes on behaviour
// - Port B flags change only on a detected port B clock rising edge.
// - Port A and port B edges are handled independently, coincident or not.
// - Port A data drivers are off whenever port A select is high.
// - Port B data drivers are off whenever port B select is high.
// - Standard mode: port A empty flag shows B-to-A queue emptiness.
// - Fall-through mode: port A flag shows valid B-to-A word on outputs.
// - Port A empty flag changes only on a port A clock rising edge.
// - Standard mode: port B empty flag shows A-to-B queue emptiness.
// - Fall-through mode: port B flag shows valid A-to-B word on outputs.
// - Standard mode: port A full flag shows A-to-B queue fullness.
// - Fall-through mode: port A full flag shows A-to-B space for a write.
// - Port A full flag changes only on a port A clock rising edge.
// - Standard mode: port B full flag shows B-to-A queue fullness.
// - Fall-through mode: port B full flag shows B-to-A space for a write.
// - Timing strap taken after reset: high standard, low fall-through; held static.
package dbf_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int DATA_W        = 36;
	localparam int DEPTH_LOG     = 6;
	localparam int ALMOST_OFFSET = 8;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic        DIR_READ    = 1'h1;
	localparam logic        FLAG_RESET  = 1'h0;
	localparam logic [1:0]  STRAP_WAIT  = 2'h2;
	localparam logic [1:0]  STRAP_DONE  = 2'h3;
	localparam logic [35:0] DOUT_RESET  = 36'h0;

	// Timing mode chosen by the strap
	typedef enum logic {DBF_STANDARD, DBF_FALL_THROUGH} dbf_mode_t;

endpackage

//--- rtl/dbf_port_flags.sv
// Two-port queue pair with port qualifiers and status flags
`timescale 1ns/1ps
`default_nettype none
module dbf_port_flags
	import dbf_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int DL = DEPTH_LOG,
	parameter int AO = ALMOST_OFFSET
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// Timing mode strap
	input  wire logic          fall_through_timing,
	// Port A controls
	input  wire logic          port_a_clock,
	input  wire logic          port_a_select_n,
	input  wire logic          port_a_enable,
	input  wire logic          port_a_read,
	// Port A data
	input  wire logic [DW-1:0] port_a_data_in,
	output logic      [DW-1:0] port_a_data_out,
	output logic               port_a_data_oe,
	// Port A flags
	output logic               port_a_empty_flag,
	output logic               port_a_full_flag,
	output logic               port_a_almost_empty_n,
	output logic               port_a_almost_full_n,
	// Port B controls
	input  wire logic          port_b_clock,
	input  wire logic          port_b_select_n,
	input  wire logic          port_b_enable,
	input  wire logic          port_b_read,
	// Port B data
	input  wire logic [DW-1:0] port_b_data_in,
	output logic      [DW-1:0] port_b_data_out,
	output logic               port_b_data_oe,
	// Port B flags
	output logic               port_b_empty_flag,
	output logic               port_b_full_flag,
	output logic               port_b_almost_empty_n,
	output logic               port_b_almost_full_n
);
	localparam int            CW       = DL + 1;
	localparam logic [CW-1:0] DEPTH_C  = CW'(2 ** DL);
	localparam logic [CW-1:0] ALMOST_C = CW'(AO);

	logic [1:0]    pin_clk, pin_sel_n, pin_en, pin_rd;
	logic [DW-1:0] pin_din [2];
	logic [1:0]    clk_s1_ff, clk_s2_ff, clk_prev_ff;
	logic [1:0]    sel_s1_ff, sel_s2_ff, en_s1_ff, en_s2_ff;
	logic [1:0]    rd_s1_ff, rd_s2_ff;
	logic [DW-1:0] din_s1_ff [2];
	logic [DW-1:0] din_s2_ff [2];
	logic [DW-1:0] dout_ff [2];
	logic [DW-1:0] q_head [2];
	logic [CW-1:0] q_count [2];
	logic [CW-1:0] rd_left [2];
	logic [1:0]    q_empty, q_full;
	logic [1:0]    edge_w, rd_w, wr_w, push_w, pop_w;
	logic [1:0]    valid_ff, ef_ff, ff_ff, ae_n_ff, af_n_ff, oe_ff;
	logic [1:0]    nxt_valid, nxt_ef, nxt_ff, nxt_ae_n, nxt_af_n;
	logic          strap_s1_ff, strap_s2_ff;
	logic [1:0]    strap_cnt_ff;
	dbf_mode_t     mode_ff;
	logic          std_mode;

	// ----------------------------------------------------------------
	// Pin gathering, index 0 is port A, index 1 is port B
	// ----------------------------------------------------------------
	assign pin_clk    = {port_b_clock, port_a_clock};
	assign pin_sel_n  = {port_b_select_n, port_a_select_n};
	assign pin_en     = {port_b_enable, port_a_enable};
	assign pin_rd     = {port_b_read, port_a_read};
	assign pin_din[0] = port_a_data_in;
	assign pin_din[1] = port_b_data_in;

	// Two-stage synchronisers on control pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clk_s1_ff   <= '0;
			clk_s2_ff   <= '0;
			clk_prev_ff <= '0;
			sel_s1_ff   <= 2'h3;
			sel_s2_ff   <= 2'h3;
			en_s1_ff    <= '0;
			en_s2_ff    <= '0;
			rd_s1_ff    <= '0;
			rd_s2_ff    <= '0;
		end else begin
			clk_s1_ff   <= pin_clk;
			clk_s2_ff   <= clk_s1_ff;
			clk_prev_ff <= clk_s2_ff;
			sel_s1_ff   <= pin_sel_n;
			sel_s2_ff   <= sel_s1_ff;
			en_s1_ff    <= pin_en;
			en_s2_ff    <= en_s1_ff;
			rd_s1_ff    <= pin_rd;
			rd_s2_ff    <= rd_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// Timing mode strap, caught once the synchroniser holds a pin value
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strap_s1_ff  <= 1'h1;
			strap_s2_ff  <= 1'h1;
			strap_cnt_ff <= '0;
			mode_ff      <= DBF_STANDARD;
		end else begin
			strap_s1_ff <= fall_through_timing;
			strap_s2_ff <= strap_s1_ff;
			if (strap_cnt_ff != STRAP_DONE) begin
				strap_cnt_ff <= strap_cnt_ff + 2'h1;
			end
			if (strap_cnt_ff == STRAP_WAIT) begin
				mode_ff <= strap_s2_ff ? DBF_STANDARD : DBF_FALL_THROUGH;
			end
		end
	end

	assign std_mode = (mode_ff == DBF_STANDARD);

	// ----------------------------------------------------------------
	// Per-port logic; port g writes queue g and reads queue 1-g
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_port
		localparam int RQ = 1 - g;

		// Data pin synchroniser
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				din_s1_ff[g] <= '0;
				din_s2_ff[g] <= '0;
			end else begin
				din_s1_ff[g] <= pin_din[g];
				din_s2_ff[g] <= din_s1_ff[g];
			end
		end

		// Edge detect and transfer qualifiers
		assign edge_w[g] = clk_s2_ff[g] & ~clk_prev_ff[g];
		assign rd_w[g]   = edge_w[g] & ~sel_s2_ff[g] & en_s2_ff[g]
			& (rd_s2_ff[g] == DIR_READ);
		assign wr_w[g]   = edge_w[g] & ~sel_s2_ff[g] & en_s2_ff[g]
			& (rd_s2_ff[g] != DIR_READ);

		// Writes only while the flag shows room
		assign push_w[g] = wr_w[g] & ff_ff[g] & ~q_full[g];

		// Standard pops on a read; fall-through refills the output word
		assign pop_w[g] = ~q_empty[RQ] & (std_mode ? (rd_w[g] & ef_ff[g])
			: (edge_w[g] & (~valid_ff[g] | rd_w[g])));

		// Next flag values
		assign rd_left[g]   = q_count[RQ] - CW'(pop_w[g]);
		assign nxt_valid[g] = ~std_mode & (pop_w[g] | (valid_ff[g] & ~rd_w[g]));
		assign nxt_ef[g]    = std_mode ? (rd_left[g] != '0) : nxt_valid[g];
		assign nxt_ff[g]    = (q_count[g] + CW'(push_w[g])) < DEPTH_C;
		assign nxt_ae_n[g]  = rd_left[g] > ALMOST_C;
		assign nxt_af_n[g]  = (DEPTH_C - q_count[g] - CW'(push_w[g])) > ALMOST_C;

		// Flags move only on this port's own clock edge
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				ef_ff[g]   <= FLAG_RESET;
				ff_ff[g]   <= FLAG_RESET;
				ae_n_ff[g] <= FLAG_RESET;
				af_n_ff[g] <= FLAG_RESET;
			end else if (edge_w[g]) begin
				ef_ff[g]   <= nxt_ef[g];
				ff_ff[g]   <= nxt_ff[g];
				ae_n_ff[g] <= nxt_ae_n[g];
				af_n_ff[g] <= nxt_af_n[g];
			end
		end

		// Output word, its valid mark and the driver enable
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				dout_ff[g]  <= DOUT_RESET;
				valid_ff[g] <= 1'h0;
				oe_ff[g]    <= 1'h0;
			end else begin
				valid_ff[g] <= nxt_valid[g];
				oe_ff[g]    <= ~sel_s2_ff[g] & (rd_s2_ff[g] == DIR_READ);
				if (pop_w[g]) begin
					dout_ff[g] <= q_head[RQ];
				end
			end
		end

		// Queue fed by this port
		dbf_queue #(
			.DW (DW),
			.DL (DL)
		) u_queue (
			.clk       (clk),
			.sys_rst   (sys_rst),
			.push      (push_w[g]),
			.push_data (din_s2_ff[g]),
			.pop       (pop_w[RQ]),
			.head_data (q_head[g]),
			.count     (q_count[g]),
			.empty     (q_empty[g]),
			.full      (q_full[g])
		);
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign port_a_data_out       = dout_ff[0];
	assign port_a_data_oe        = oe_ff[0];
	assign port_a_empty_flag     = ef_ff[0];
	assign port_a_full_flag      = ff_ff[0];
	assign port_a_almost_empty_n = ae_n_ff[0];
	assign port_a_almost_full_n  = af_n_ff[0];
	assign port_b_data_out       = dout_ff[1];
	assign port_b_data_oe        = oe_ff[1];
	assign port_b_empty_flag     = ef_ff[1];
	assign port_b_full_flag      = ff_ff[1];
	assign port_b_almost_empty_n = ae_n_ff[1];
	assign port_b_almost_full_n  = af_n_ff[1];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_b_flags_hold: assert property (!edge_w[1] |=>
		$stable(ef_ff[1]) && $stable(ff_ff[1]) && $stable(ae_n_ff[1]) && $stable(af_n_ff[1]))
		else $error("port B flag moved off its edge");
	a_a_empty_hold: assert property (!edge_w[0] |=> $stable(ef_ff[0]))
		else $error("port A empty flag moved off its edge");
	a_a_full_hold: assert property (!edge_w[0] |=> $stable(ff_ff[0]))
		else $error("port A full flag moved off its edge");
	a_pop_own_edge: assert property (pop_w[1] |-> edge_w[1] && !$past(edge_w[1]))
		else $error("port B pop without its own edge");
	a_a_hiz_select: assert property (sel_s2_ff[0] |=> !port_a_data_oe)
		else $error("port A driving while deselected");
	a_b_hiz_select: assert property (sel_s2_ff[1] |=> !port_b_data_oe)
		else $error("port B driving while deselected");
	a_a_std_empty: assert property (std_mode && edge_w[0] && q_empty[1] |=> !ef_ff[0])
		else $error("port A empty flag missed empty queue");
	a_a_fall_through_timing_ready: assert property (!std_mode |-> ef_ff[0] == valid_ff[0])
		else $error("port A ready flag without valid word");
	a_b_std_empty: assert property (std_mode && edge_w[1] && q_empty[0] |=> !ef_ff[1])
		else $error("port B empty flag missed empty queue");
	a_b_fall_through_timing_ready: assert property (!std_mode |-> ef_ff[1] == valid_ff[1])
		else $error("port B ready flag without valid word");
	a_a_std_full: assert property (std_mode && edge_w[0] && q_full[0] |=> !ff_ff[0])
		else $error("port A full flag missed full queue");
	a_a_fall_through_timing_room: assert property (!std_mode && ff_ff[0] |-> !q_full[0])
		else $error("port A input ready on full queue");
	a_b_std_full: assert property (std_mode && edge_w[1] && q_full[1] |=> !ff_ff[1])
		else $error("port B full flag missed full queue");
	a_b_fall_through_timing_room: assert property (!std_mode && ff_ff[1] |-> !q_full[1])
		else $error("port B input ready on full queue");
	a_mode_static: assert property (strap_cnt_ff == STRAP_DONE |=> $stable(mode_ff))
		else $error("timing mode changed after capture");
	a_push_qualified: assert property (push_w[0] |->
		!sel_s2_ff[0] && en_s2_ff[0] && rd_s2_ff[0] != DIR_READ ##1 q_count[0] != '0)
		else $error("port A write not qualified");

	c_fall_through_timing_read_a: cover property (!std_mode && rd_w[0] && valid_ff[0]);
	c_std_full_b: cover property (std_mode && wr_w[1] && !ff_ff[1]);
	c_both_edges: cover property (edge_w[0] && edge_w[1]);

endmodule // dbf_port_flags
`default_nettype wire

//--- rtl/dbf_queue.sv
// Flip-flop queue with independent push and pop
`timescale 1ns/1ps
`default_nettype none
module dbf_queue
	import dbf_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int DL = DEPTH_LOG
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// Write side
	input  wire logic          push,
	input  wire logic [DW-1:0] push_data,
	// Read side
	input  wire logic          pop,
	output logic      [DW-1:0] head_data,
	// State
	output logic      [DL:0]   count,
	output logic               empty,
	output logic               full
);
	localparam int            CW      = DL + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(2 ** DL);

	logic [DW-1:0] mem_ff [2 ** DL];
	logic [DL-1:0] wr_ptr_ff;
	logic [DL-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;
	logic          do_push;
	logic          do_pop;

	// ----------------------------------------------------------------
	// Qualified moves
	// ----------------------------------------------------------------
	assign do_push   = push & ~full;
	assign do_pop    = pop & ~empty;
	assign empty     = (count_ff == '0);
	assign full      = (count_ff == DEPTH_C);
	assign count     = count_ff;
	assign head_data = mem_ff[rd_ptr_ff];

	// Storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= push_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + DL'(do_push);
			rd_ptr_ff <= rd_ptr_ff + DL'(do_pop);
			count_ff  <= count_ff + CW'(do_push) - CW'(do_pop);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
		count_ff == $past(count_ff) + CW'($past(do_push)) - CW'($past(do_pop)))
		else $error("queue level moved wrongly");
	a_level_bound: assert property (@(posedge clk) disable iff (sys_rst)
		count_ff <= DEPTH_C)
		else $error("queue level beyond depth");

endmodule // dbf_queue
`default_nettype wire
